// >>> rtl/wwd_consts.svh
// constants for the windowed watchdog: register offsets, field positions, reset values, prescaler
// assumes inclusion by bare name from the watchdog package and module
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH

`define WWD_ADDR_W 4
`define WWD_OFF_CONTROL 4'h0
`define WWD_OFF_MODE 4'h4
`define WWD_OFF_STATUS 4'h8

`define WWD_KEY_HI 31
`define WWD_KEY_LO 24
`define WWD_KEY_VALUE 8'hA5
`define WWD_RESTART_BIT 0

`define WWD_RELOAD_HI 11
`define WWD_RELOAD_LO 0
`define WWD_FIEN_BIT 12
`define WWD_RSTEN_BIT 13
`define WWD_PROC_BIT 14
`define WWD_DIS_BIT 15
`define WWD_DELTA_HI 27
`define WWD_DELTA_LO 16
`define WWD_DBGHLT_BIT 28
`define WWD_IDLEHLT_BIT 29
`define WWD_MODE_MASK 32'h3FFF_FFFF
`define WWD_MODE_RESET 32'h3FFF_2FFF

`define WWD_UNF_BIT 0
`define WWD_ERR_BIT 1

`define WWD_PRESCALE_DIV 128
`define WWD_PRESCALE_W 7
`define WWD_PRESCALE_LAST 7'h7F
`define WWD_COUNT_ZERO 12'h000
`define WWD_RELOAD_RESET 12'hFFF

`endif

// >>> rtl/wwd_pkg.sv
// types shared by the windowed watchdog
// assumes the constants header is on the include path
`include "wwd_consts.svh"

package wwd_pkg;
    typedef logic [31:0] wwd_word_t;
    typedef logic [`WWD_ADDR_W-1:0] wwd_addr_t;
    typedef logic [11:0] wwd_count_t;
    // scope of a requested reset
    typedef enum logic [1:0] {
        WWD_RST_NONE,
        WWD_RST_PROC,
        WWD_RST_ALL
    } wwd_rst_scope_t;
endpackage : wwd_pkg

// >>> rtl/wwd_watchdog.sv
// windowed watchdog: 12-bit down counter on the clock divided by 128, key-protected restart,
// write-once mode register, read-to-clear status, fault interrupt and reset request.
// assumes a simple register port (read data one cycle after the read strobe) and that
// the debug, idle and system reset indications arrive synchronous to CLK_IN.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "wwd_consts.svh"

module wwd_watchdog (
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire wwd_pkg::wwd_addr_t ADDR_IN,
    input wire wwd_pkg::wwd_word_t WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic DEBUG_IN,
    input wire logic IDLE_IN,
    input wire logic SYS_RESET_DONE_IN,
    output logic [31:0] RDATA_OUT,
    output logic IRQ_OUT,
    output logic FAULT_OUT,
    output logic PROC_RESET_REQ_OUT,
    output logic ALL_RESET_REQ_OUT,
    output logic [11:0] COUNT_OUT
);
    import wwd_pkg::*;

    // register state and next values
    wwd_word_t mode_q;
    logic mode_locked_q;
    wwd_count_t count_q;
    wwd_count_t count_d;
    logic [`WWD_PRESCALE_W-1:0] presc_q;
    logic [`WWD_PRESCALE_W-1:0] presc_d;
    logic unf_q;
    logic err_q;
    logic irq_q;
    logic fault_q;
    logic proc_req_q;
    logic all_req_q;
    wwd_rst_scope_t scope_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // decoded bus strobes
    logic ctl_wr;
    logic key_ok;
    logic restart_cmd;
    logic mode_wr;
    logic status_rd;

    // window, timing and fault events
    logic in_window;
    logic good_restart;
    logic win_error;
    logic halt_dis;
    logic halt_dbg;
    logic halt_idle;
    logic halted;
    logic tick;
    logic underflow;
    logic clear_all;
    logic fault_ev;
    logic irq_set;
    logic fault_set;
    logic req_ev;

    // bus decode: the key guards only the restart bit, not the control write decode itself
    always_comb begin
        ctl_wr = 1'b0;
        key_ok = 1'b0;
        restart_cmd = 1'b0;
        mode_wr = 1'b0;
        status_rd = 1'b0;
        if (WR_IN && ADDR_IN == `WWD_OFF_CONTROL) begin
            ctl_wr = 1'b1;
        end
        if (WDATA_IN[`WWD_KEY_HI:`WWD_KEY_LO] == `WWD_KEY_VALUE) begin
            key_ok = 1'b1;
        end
        if (ctl_wr && key_ok && WDATA_IN[`WWD_RESTART_BIT]) begin
            restart_cmd = 1'b1;
        end
        // once locked, later mode writes leave no trace at all
        if (WR_IN && ADDR_IN == `WWD_OFF_MODE && !mode_locked_q) begin
            mode_wr = 1'b1;
        end
        if (RD_IN && ADDR_IN == `WWD_OFF_STATUS) begin
            status_rd = 1'b1;
        end
    end

    // window check runs even with the timer disabled
    always_comb begin
        in_window = 1'b0;
        good_restart = 1'b0;
        win_error = 1'b0;
        if (count_q <= mode_q[`WWD_DELTA_HI:`WWD_DELTA_LO]) begin
            in_window = 1'b1;
        end
        if (restart_cmd) begin
            if (in_window) begin
                good_restart = 1'b1;
            end else begin
                win_error = 1'b1;
            end
        end
    end

    // any halt source freezes prescaler and counter together
    always_comb begin
        halt_dis = mode_q[`WWD_DIS_BIT];
        halt_dbg = mode_q[`WWD_DBGHLT_BIT] && DEBUG_IN;
        halt_idle = mode_q[`WWD_IDLEHLT_BIT] && IDLE_IN;
        halted = halt_dis || halt_dbg || halt_idle;
    end

    // the prescaler wraps on its own, so its last count is the tick
    always_comb begin
        tick = 1'b0;
        if (!halted && presc_q == `WWD_PRESCALE_LAST) begin
            tick = 1'b1;
        end
    end

    // an underflow reloads and counts again, so faults repeat every period until serviced
    always_comb begin
        underflow = 1'b0;
        if (tick && count_q == `WWD_COUNT_ZERO) begin
            underflow = 1'b1;
        end
    end

    always_comb begin
        clear_all = 1'b0;
        if (status_rd || SYS_RESET_DONE_IN) begin
            clear_all = 1'b1;
        end
    end

    always_comb begin
        fault_ev = underflow || win_error;
        irq_set = fault_ev && mode_q[`WWD_FIEN_BIT];
        // a window error reaches the fault line whatever the reset enable says
        fault_set = win_error || (underflow && mode_q[`WWD_RSTEN_BIT]);
        req_ev = fault_ev && mode_q[`WWD_RSTEN_BIT];
    end

    // mode register: one write after reset
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            mode_q <= `WWD_MODE_RESET;
        end else if (mode_wr) begin
            mode_q <= WDATA_IN & `WWD_MODE_MASK;
        end
    end

    // lock bit: only the module reset RST_B_IN reopens the mode register
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            mode_locked_q <= 1'b0;
        end else if (mode_wr) begin
            mode_locked_q <= 1'b1;
        end
    end

    // prescaler: cleared on restart or mode write so the first tick is a full period away
    always_comb begin
        presc_d = presc_q;
        if (good_restart || mode_wr) begin
            presc_d = '0;
        end else if (!halted) begin
            presc_d = presc_q + 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_d;
        end
    end

    // down counter; a mode write wins over a restart in the same cycle
    always_comb begin
        count_d = count_q;
        if (mode_wr) begin
            count_d = WDATA_IN[`WWD_RELOAD_HI:`WWD_RELOAD_LO];
        end else if (good_restart || underflow) begin
            count_d = mode_q[`WWD_RELOAD_HI:`WWD_RELOAD_LO];
        end else if (tick) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            count_q <= `WWD_RELOAD_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // sticky flags: a new event in the clearing cycle wins over the clear
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            unf_q <= 1'b0;
        end else if (underflow) begin
            unf_q <= 1'b1;
        end else if (clear_all) begin
            unf_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            err_q <= 1'b0;
        end else if (win_error) begin
            err_q <= 1'b1;
        end else if (clear_all) begin
            err_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            irq_q <= 1'b0;
        end else if (irq_set) begin
            irq_q <= 1'b1;
        end else if (clear_all) begin
            irq_q <= 1'b0;
        end
    end

    // fault line: underflow only when reset is enabled; window error always
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            fault_q <= 1'b0;
        end else if (fault_set) begin
            fault_q <= 1'b1;
        end else if (clear_all) begin
            fault_q <= 1'b0;
        end
    end

    // scope of a new request
    always_comb begin
        scope_d = WWD_RST_NONE;
        if (req_ev) begin
            scope_d = mode_q[`WWD_PROC_BIT] ? WWD_RST_PROC : WWD_RST_ALL;
        end
    end

    // reset requests held until the reset controller reports the reset done
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            proc_req_q <= 1'b0;
            all_req_q <= 1'b0;
        end else if (req_ev) begin
            proc_req_q <= scope_d == WWD_RST_PROC;
            all_req_q <= scope_d == WWD_RST_ALL;
        end else if (SYS_RESET_DONE_IN) begin
            proc_req_q <= 1'b0;
            all_req_q <= 1'b0;
        end
    end

    // read port: control and unmapped offsets read as zero
    always_comb begin
        rdata_d = '0;
        if (RD_IN) begin
            unique case (ADDR_IN)
                `WWD_OFF_MODE: begin
                    rdata_d = mode_q;
                end
                `WWD_OFF_STATUS: begin
                    rdata_d[`WWD_UNF_BIT] = unf_q;
                    rdata_d[`WWD_ERR_BIT] = err_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    // read data stand for one cycle only, then return to zero
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // every output straight from its flip-flop
    assign RDATA_OUT = rdata_q;
    assign IRQ_OUT = irq_q;
    assign FAULT_OUT = fault_q;
    assign PROC_RESET_REQ_OUT = proc_req_q;
    assign ALL_RESET_REQ_OUT = all_req_q;
    assign COUNT_OUT = count_q;
endmodule : wwd_watchdog
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the windowed watchdog
// assumes register port with read data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import wwd_pkg::*;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, dbg = 0, idle = 0, irq, flt, preq, areq, done;
    wwd_addr_t adr = '0;
    wwd_word_t wd = '0;
    logic [31:0] rdata;
    logic [11:0] cnt, c;
    int fail_count = 0, n_tests = 0;
    wwd_watchdog i_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(adr), .WDATA_IN(wd), .WR_IN(wr),
        .RD_IN(rd), .DEBUG_IN(dbg), .IDLE_IN(idle), .SYS_RESET_DONE_IN(done), .RDATA_OUT(rdata),
        .IRQ_OUT(irq), .FAULT_OUT(flt), .PROC_RESET_REQ_OUT(preq), .ALL_RESET_REQ_OUT(areq),
        .COUNT_OUT(cnt));
    wwd_rstc_model i_rstc (.clk_in(clk), .rst_b_in(rst_b), .proc_req_in(preq), .all_req_in(areq),
        .done_out(done));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wrt(input wwd_addr_t a, input wwd_word_t d);
        @(posedge clk);
        wr <= 1'b1;
        adr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wrt
    task automatic rdc(input wwd_addr_t a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        adr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rdc
    task automatic rst_pulse;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
    endtask : rst_pulse
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        #250000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdc(4'h4, 32'h3FFF_2FFF);
        rdc(4'h8, 32'h0);
        rdc(4'h0, 32'h0);
        chk(cnt, 12'hFFF);
        $display("reset values done");
        // delta 2, reload 5, debug halt, processor-only reset, irq on
        wrt(4'h4, 32'h1002_7005);
        chk(cnt, 12'h005);
        wrt(4'h4, 32'h0000_8FFF);
        rdc(4'h4, 32'h1002_7005);
        wrt(4'h0, 32'h5A00_0001);
        wrt(4'h0, 32'hA500_0000);
        chk(flt, 1'b0);
        wrt(4'h0, 32'hA500_0001);
        chk({irq, flt, preq, areq}, 4'hE);
        rdc(4'h8, 32'h2);
        chk({irq, flt}, 2'h0);
        repeat (10) @(posedge clk);
        rdc(4'h8, 32'h0);
        chk(preq, 1'b0);
        $display("window error done");
        @(posedge clk);
        dbg <= 1'b1;
        #1;
        c = cnt;
        repeat (300) @(posedge clk);
        #1;
        chk(cnt, c);
        @(posedge clk);
        dbg <= 1'b0;
        idle <= 1'b1;
        for (int i = 0; i < 1000 && flt !== 1'b1; i++) @(posedge clk);
        #1;
        chk({flt, preq, cnt}, {2'h3, 12'h005});
        rdc(4'h8, 32'h1);
        for (int i = 0; i < 1000 && cnt !== 12'h002; i++) @(posedge clk);
        wrt(4'h0, 32'hA500_0001);
        chk({flt, cnt}, {1'b0, 12'h005});
        repeat (127) @(posedge clk);
        #1;
        chk(cnt, 12'h005);
        @(posedge clk);
        #1;
        chk(cnt, 12'h004);
        $display("counting done");
        rst_pulse();
        wrt(4'h4, 32'h0000_2003);
        wrt(4'h0, 32'hA500_0001);
        chk({irq, flt, preq, areq}, 4'h5);
        rdc(4'h8, 32'h2);
        $display("all-reset scope done");
        rst_pulse();
        wrt(4'h4, 32'h2000_0007);
        repeat (300) @(posedge clk);
        #1;
        chk(cnt, 12'h007);
        rst_pulse();
        idle <= 1'b0;
        wrt(4'h4, 32'h0000_8007);
        repeat (300) @(posedge clk);
        #1;
        chk(cnt, 12'h007);
        wrt(4'h0, 32'hA500_0001);
        chk({flt, preq, areq}, 3'h4);
        $display("halt and disable done");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire

// >>> verification/wwd_rstc_model.sv
// reset controller stand-in: answers a reset request with a one-cycle done pulse
// assumes requests are levels held until done
`timescale 1ns/1ps
`default_nettype none
module wwd_rstc_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic proc_req_in,
    input wire logic all_req_in,
    output logic done_out
);
    logic [3:0] cnt_q;
    // slow answer leaves the bench time to read the flags first
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= 4'h0;
            done_out <= 1'b0;
        end else begin
            done_out <= (cnt_q == 4'h6);
            cnt_q <= ((proc_req_in || all_req_in) && !done_out) ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule : wwd_rstc_model
`default_nettype wire

// >>> verification/wwd_watchdog_sva.sv
// port-level checks for the windowed watchdog
// assumes binding onto wwd_watchdog, single clock domain
`timescale 1ns/1ps
`default_nettype none
module wwd_watchdog_chk (
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire wwd_pkg::wwd_addr_t ADDR_IN,
    input wire wwd_pkg::wwd_word_t WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic SYS_RESET_DONE_IN,
    input wire logic [31:0] RDATA_OUT,
    input wire logic IRQ_OUT,
    input wire logic FAULT_OUT,
    input wire logic PROC_RESET_REQ_OUT,
    input wire logic ALL_RESET_REQ_OUT,
    input wire logic [11:0] COUNT_OUT
);
    import wwd_pkg::*;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    sequence s_st_rd;
        RD_IN && ADDR_IN == 4'h8;
    endsequence
    // guard on a nonzero count: an underflow in the same cycle would win over the clear
    sequence s_quiet;
        !WR_IN && COUNT_OUT != 12'h000;
    endsequence
    property p_ctl_rd;
        RD_IN && ADDR_IN == 4'h0 |=> RDATA_OUT == 32'h0;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control read not zero");
    property p_st_bits;
        s_st_rd |=> RDATA_OUT[31:2] == 30'h0;
    endproperty
    a_st_bits: assert property (p_st_bits) else $error("status upper bits set");
    property p_mode_bits;
        RD_IN && ADDR_IN == 4'h4 |=> RDATA_OUT[31:30] == 2'h0;
    endproperty
    a_mode_bits: assert property (p_mode_bits) else $error("mode bits 31:30 set");
    property p_step;
        !$past(WR_IN) && COUNT_OUT != $past(COUNT_OUT) && $past(COUNT_OUT) != 12'h000
            |-> COUNT_OUT == $past(COUNT_OUT) - 12'h001;
    endproperty
    a_step: assert property (p_step) else $error("counter jumped");
    property p_bad_key;
        WR_IN && ADDR_IN == 4'h0 && WDATA_IN[31:24] != 8'hA5 && !FAULT_OUT && COUNT_OUT != 12'h000
            |=> !FAULT_OUT;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("keyless write acted");
    property p_rd_clr;
        s_st_rd and s_quiet |=> !FAULT_OUT && !IRQ_OUT;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("status read did not clear");
    property p_done_clr;
        SYS_RESET_DONE_IN ##0 s_quiet |=> !FAULT_OUT && !PROC_RESET_REQ_OUT && !ALL_RESET_REQ_OUT;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("reset did not clear");
    property p_one_scope;
        !(PROC_RESET_REQ_OUT && ALL_RESET_REQ_OUT);
    endproperty
    a_one_scope: assert property (p_one_scope) else $error("both reset scopes");
    property p_req_flt;
        $rose(PROC_RESET_REQ_OUT) || $rose(ALL_RESET_REQ_OUT) |-> FAULT_OUT;
    endproperty
    a_req_flt: assert property (p_req_flt) else $error("request without fault");
endmodule : wwd_watchdog_chk
bind wwd_watchdog wwd_watchdog_chk i_chk (.*);
`default_nettype wire
